// >>> bbclk_pkg.sv
// constants for the baseband clock, loopback and scan control block
package bbclk_pkg;

   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_RX_STATUS   = 8'h0E;
   localparam logic [7:0] IDX_RX_MASK     = 8'h0F;
   localparam logic [7:0] IDX_PHASE_STEP  = 8'h10;
   localparam logic [7:0] IDX_CLOCK_STOP  = 8'h11;
   localparam logic [7:0] IDX_POWER_DOWN  = 8'h12;
   localparam logic [7:0] IDX_LOOPBACK    = 8'h13;
   localparam logic [7:0] IDX_SCAN_CTRL   = 8'h14;

   // writable bits of each register; the rest store and read as zero
   localparam logic [7:0] MASK_RX_MASK    = 8'h7E;
   localparam logic [7:0] MASK_PHASE_STEP = 8'h07;
   localparam logic [7:0] MASK_CLOCK_STOP = 8'h3F;
   localparam logic [7:0] MASK_POWER_DOWN = 8'h3F;
   localparam logic [7:0] MASK_LOOPBACK   = 8'hFF;
   localparam logic [7:0] MASK_SCAN_CTRL  = 8'h3F;

   localparam logic [7:0] RST_REG         = 8'h00;

   // clock stop bits
   localparam int CS_RX_AUTO   = 0;
   localparam int CS_SER_AUTO  = 1;
   localparam int CS_RAMDAC    = 2;
   localparam int CS_RXPORT    = 3;
   localparam int CS_FIFO      = 4;
   localparam int CS_TX_AUTO   = 5;
   // power down bits
   localparam int PD_DAC_LSB   = 0;
   localparam int PD_BIAS      = 4;
   localparam int PD_FAST_PINS = 5;
   // loopback bits
   localparam int LB_DIGITAL   = 0;
   localparam int LB_TX_ACCESS = 1;
   localparam int LB_RX_ACCESS = 2;
   localparam int LB_ANALOGUE  = 3;
   localparam int LB_CODEC     = 4;
   localparam int LB_IIR       = 5;
   localparam int LB_TX_FILT   = 6;
   localparam int LB_RX_FILT   = 7;
   // scan control bits
   localparam int SC_RAM_SRC   = 0;
   localparam int SC_AUTO      = 1;
   localparam int SC_DIR       = 2;
   localparam int SC_RATE_LSB  = 3;

   // slowest scan divisor, symbol periods of silence before serial power down
   localparam logic [9:0] SCAN_DIV_MAX    = 10'h200;
   localparam logic [2:0] SER_IDLE_SYMS   = 3'h6;

   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   typedef enum logic {SCAN_IDLE, SCAN_RUN} scan_state_t;

endpackage

// >>> baseband_clock_loopback_control.sv
// register bank for clock stop, power down, loopback, phase step and ram dac scan
//
// What this block does
// - mask bits 6..1 let receive flags interrupt
// - every phase write with byte lane 0 strobed steps phase once
// - phase register reads last written code
// - codes 1-3 retard, 4-7 advance eighths
// - tx auto stop gates tx clock
// - fifo clock follows clock stop bit 4
// - bits 3,2 power down port, ram dac
// - serial stops after idle symbols, frame sync restarts
// - rx auto stop gates rx clock
// - power down bias chain and aux dacs
// - bits 7,6 bypass converter passive filters
// - bit 5 bypasses iir, 32k, 16-bit codec
// - bits 3,4 analogue and codec loopback
// - bits 2,1 enable data access points
// - digital loopback alternates I and Q samples
// - scan rate divisor 512 down to 4
// - direction bit up to top, down to bottom
// - direction change waits for scan end
// - auto cycle bounces top to bottom forever
// - bit 0 picks ram or register dac1
// - receive flags latch until status read
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module baseband_clock_loopback_control
   import bbclk_pkg::*;
#(
   parameter int ADDR_W  = 12,
   parameter int SAMP_W  = 16,
   parameter int RAM_AW  = 6,
   parameter int DAC_W   = 10
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [6:1]          rxFlagEvents,
   output logic                     rxIrq,
   output logic                     phaseStepPulse,
   output logic                     phaseRetard,
   output logic                     phaseAdvance,
   output logic [2:0]               phaseEighths,
   input  wire logic                txPathEnable,
   input  wire logic                rxPathEnable,
   output logic                     txClockRun,
   output logic                     rxClockRun,
   output logic                     fifoClockRun,
   output logic                     rxPortPowerDown,
   output logic                     ramDacPowerDown,
   input  wire logic                symbolTick,
   input  wire logic [2:0]          frameSync,
   output logic                     serialPowerDown,
   output logic                     biasPowerDown,
   output logic [3:0]               auxDacPowerDown,
   output logic                     fastPins,
   output logic                     rxFilterBypass,
   output logic                     txFilterBypass,
   output logic                     iirBypass,
   output logic                     codecRate32k,
   output logic                     codecWord16,
   output logic                     codecLoopback,
   output logic                     analogueLoopback,
   output logic                     rxAccessEnable,
   output logic                     txAccessEnable,
   output logic                     digitalLoopback,
   input  wire logic                sampleTick,
   input  wire logic [SAMP_W-1:0]   txOperI,
   input  wire logic [SAMP_W-1:0]   txOperQ,
   output logic [SAMP_W-1:0]        rxPortData,
   output logic                     rxPortIsQ,
   output logic [RAM_AW-1:0]        ramAddr,
   input  wire logic [DAC_W-1:0]    ramData,
   input  wire logic [DAC_W-1:0]    auxDac1Value,
   output logic [DAC_W-1:0]         dac1Data
);

   localparam logic [RAM_AW-1:0] PTR_TOP = '1;

   typedef struct packed {
      logic [7:0]         rxMask;
      logic [7:0]         rxStatus;
      logic [7:0]         phaseCode;
      logic [7:0]         clockStop;
      logic [7:0]         powerDown;
      logic [7:0]         loopback;
      logic [7:0]         scanCtrl;
      logic               awHave;
      logic [7:0]         awIdx;
      logic               wHave;
      logic [7:0]         wData;
      logic               wLane0;
      logic               bValid;
      logic [1:0]         bResp;
      logic               rValid;
      logic [31:0]        rData;
      logic [1:0]         rResp;
      logic               stepPulse;
      logic [2:0]         idleSyms;
      logic               serialDown;
      logic               loopIsQ;
      logic [SAMP_W-1:0]  loopData;
      logic [8:0]         divCount;
      logic [RAM_AW-1:0]  ptr;
      logic               scanUp;
      scan_state_t        scanState;
      logic [DAC_W-1:0]   dac1;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic       doWrite;
   logic       arTake;
   logic [7:0] arIdx;
   logic       rdStatus;
   logic [8:0] divLimit;
   logic       scanTick;
   logic       atEnd;

   assign s_axi_awready = !s_q.awHave && !s_q.bValid;
   assign s_axi_wready  = !s_q.wHave && !s_q.bValid;
   assign s_axi_bvalid  = s_q.bValid;
   assign s_axi_bresp   = s_q.bResp;
   assign s_axi_arready = !s_q.rValid;
   assign s_axi_rvalid  = s_q.rValid;
   assign s_axi_rdata   = s_q.rData;
   assign s_axi_rresp   = s_q.rResp;

   assign doWrite  = s_q.awHave && s_q.wHave && !s_q.bValid;
   assign arTake   = s_axi_arvalid && !s_q.rValid;
   assign arIdx    = s_axi_araddr[9:2];
   assign rdStatus = arTake && (arIdx == IDX_RX_STATUS);

   // divisor 512 >> rate, so the top code gives divide by four
   assign divLimit = 9'((SCAN_DIV_MAX >> s_q.scanCtrl[SC_RATE_LSB +: 3]) - 10'h001);
   assign scanTick = (s_q.divCount >= divLimit);
   assign atEnd    = s_q.scanUp ? (s_q.ptr == PTR_TOP) : (s_q.ptr == '0);

   always_comb begin
      s_d = s_q;
      s_d.stepPulse = 1'b0;

      // write address and data arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.awHave = 1'b1;
         s_d.awIdx  = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.wHave  = 1'b1;
         s_d.wData  = s_axi_wdata[7:0];
         s_d.wLane0 = s_axi_wstrb[0];
      end
      if (doWrite) begin
         s_d.awHave = 1'b0;
         s_d.wHave  = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp  = RESP_OKAY;
         unique case (s_q.awIdx)
            IDX_RX_MASK:    if (s_q.wLane0) s_d.rxMask    = s_q.wData & MASK_RX_MASK;
            IDX_CLOCK_STOP: if (s_q.wLane0) s_d.clockStop = s_q.wData & MASK_CLOCK_STOP;
            IDX_POWER_DOWN: if (s_q.wLane0) s_d.powerDown = s_q.wData & MASK_POWER_DOWN;
            IDX_LOOPBACK:   if (s_q.wLane0) s_d.loopback  = s_q.wData & MASK_LOOPBACK;
            IDX_SCAN_CTRL:  if (s_q.wLane0) s_d.scanCtrl  = s_q.wData & MASK_SCAN_CTRL;
            IDX_PHASE_STEP: begin
               if (s_q.wLane0) begin
                  s_d.phaseCode = s_q.wData & MASK_PHASE_STEP;
                  s_d.stepPulse = 1'b1;
               end
            end
            IDX_RX_STATUS: ;
            default: s_d.bResp = RESP_SLVERR;
         endcase
      end
      if (s_q.bValid && s_axi_bready) begin
         s_d.bValid = 1'b0;
      end

      // read answer one cycle after the address is taken
      if (s_q.rValid && s_axi_rready) begin
         s_d.rValid = 1'b0;
      end
      if (arTake) begin
         s_d.rValid = 1'b1;
         s_d.rResp  = RESP_OKAY;
         s_d.rData  = '0;
         unique case (arIdx)
            IDX_RX_STATUS:  s_d.rData[7:0] = s_q.rxStatus;
            IDX_RX_MASK:    s_d.rData[7:0] = s_q.rxMask;
            IDX_PHASE_STEP: s_d.rData[7:0] = s_q.phaseCode;
            IDX_CLOCK_STOP: s_d.rData[7:0] = s_q.clockStop;
            IDX_POWER_DOWN: s_d.rData[7:0] = s_q.powerDown;
            IDX_LOOPBACK:   s_d.rData[7:0] = s_q.loopback;
            IDX_SCAN_CTRL:  s_d.rData[7:0] = s_q.scanCtrl;
            default:        s_d.rResp      = RESP_SLVERR;
         endcase
      end

      // flags latch until read; an event in the read cycle survives
      if (rdStatus) begin
         s_d.rxStatus = '0;
      end
      s_d.rxStatus[6:1] = s_d.rxStatus[6:1] | rxFlagEvents;
      s_d.rxStatus[0]   = |(s_d.rxStatus[6:1] & s_q.rxMask[6:1]);
      s_d.rxStatus[7]   = 1'b0;

      // serial interface idle watch
      if (!s_q.clockStop[CS_SER_AUTO]) begin
         s_d.idleSyms   = '0;
         s_d.serialDown = 1'b0;
      end else if (|frameSync) begin
         s_d.idleSyms   = '0;
         s_d.serialDown = 1'b0;
      end else if (symbolTick && (s_q.idleSyms != SER_IDLE_SYMS)) begin
         s_d.idleSyms   = s_q.idleSyms + 3'h1;
         s_d.serialDown = (s_q.idleSyms + 3'h1) == SER_IDLE_SYMS;
      end

      // digital loopback sample alternation
      if (s_q.loopback[LB_DIGITAL] && sampleTick) begin
         s_d.loopData = s_q.loopIsQ ? txOperQ : txOperI;
         s_d.loopIsQ  = !s_q.loopIsQ;
      end else if (!s_q.loopback[LB_DIGITAL]) begin
         s_d.loopIsQ  = 1'b0;
         s_d.loopData = '0;
      end

      // ram dac scanner
      s_d.divCount = scanTick ? '0 : s_q.divCount + 9'h001;
      unique case (s_q.scanState)
         SCAN_IDLE: begin
            if (s_q.scanCtrl[SC_RAM_SRC]) begin
               s_d.scanState = SCAN_RUN;
               s_d.scanUp    = s_q.scanCtrl[SC_DIR];
               s_d.divCount  = '0;
            end
         end
         SCAN_RUN: begin
            if (!s_q.scanCtrl[SC_RAM_SRC]) begin
               s_d.scanState = SCAN_IDLE;
            end else if (scanTick) begin
               if (!atEnd) begin
                  s_d.ptr = s_q.scanUp ? s_q.ptr + 1'b1 : s_q.ptr - 1'b1;
               end else if (s_q.scanCtrl[SC_AUTO]) begin
                  s_d.scanUp = !s_q.scanUp;
               end else begin
                  s_d.scanUp = s_q.scanCtrl[SC_DIR];
               end
            end
         end
      endcase
      s_d.dac1 = s_q.scanCtrl[SC_RAM_SRC] ? ramData : auxDac1Value;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q           <= '0;
         s_q.scanState <= SCAN_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign rxIrq          = s_q.rxStatus[0];
   assign phaseStepPulse = s_q.stepPulse;
   always_comb begin
      phaseRetard  = s_q.stepPulse && !s_q.phaseCode[2] && (s_q.phaseCode[1:0] != 2'h0);
      phaseAdvance = s_q.stepPulse && s_q.phaseCode[2];
      phaseEighths = s_q.phaseCode[2] ? 3'(3'h0 - s_q.phaseCode[2:0]) : s_q.phaseCode[2:0];
   end

   assign txClockRun       = !s_q.clockStop[CS_TX_AUTO] || txPathEnable;
   assign rxClockRun       = !s_q.clockStop[CS_RX_AUTO] || rxPathEnable;
   assign fifoClockRun     = s_q.clockStop[CS_FIFO];
   assign rxPortPowerDown  = s_q.clockStop[CS_RXPORT];
   assign ramDacPowerDown  = s_q.clockStop[CS_RAMDAC];
   assign serialPowerDown  = s_q.serialDown;
   assign biasPowerDown    = s_q.powerDown[PD_BIAS];
   assign auxDacPowerDown  = s_q.powerDown[PD_DAC_LSB +: 4];
   assign fastPins         = s_q.powerDown[PD_FAST_PINS];
   assign rxFilterBypass   = s_q.loopback[LB_RX_FILT];
   assign txFilterBypass   = s_q.loopback[LB_TX_FILT];
   assign iirBypass        = s_q.loopback[LB_IIR];
   assign codecRate32k     = s_q.loopback[LB_IIR];
   assign codecWord16      = s_q.loopback[LB_IIR];
   assign codecLoopback    = s_q.loopback[LB_CODEC];
   assign analogueLoopback = s_q.loopback[LB_ANALOGUE];
   assign rxAccessEnable   = s_q.loopback[LB_RX_ACCESS];
   assign txAccessEnable   = s_q.loopback[LB_TX_ACCESS];
   assign digitalLoopback  = s_q.loopback[LB_DIGITAL];
   assign rxPortData       = s_q.loopData;
   assign rxPortIsQ        = s_q.loopIsQ;
   assign ramAddr          = s_q.ptr;
   assign dac1Data         = s_q.dac1;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic wrPhase;
   assign wrPhase = doWrite && s_q.wLane0 && (s_q.awIdx == IDX_PHASE_STEP);

   a_irq_mask_gate: assert property ((|(rxFlagEvents & s_q.rxMask[6:1])) |=> rxIrq)
      else $error("unmasked receive flag did not raise interrupt");
   a_phase_step_once: assert property (wrPhase |=> phaseStepPulse ##1 !phaseStepPulse)
      else $error("phase write did not give a single step pulse");
   a_phase_readback: assert property (wrPhase |=> s_q.phaseCode[2:0] == $past(s_q.wData[2:0]))
      else $error("phase register lost written code");
   a_phase_decode: assert property (phaseAdvance |-> (phaseEighths + s_q.phaseCode[2:0]) == 3'h0)
      else $error("advance amount decoded wrong");
   a_tx_clock_gate: assert property (s_q.clockStop[CS_TX_AUTO] && !txPathEnable |-> !txClockRun)
      else $error("tx clock runs while gated");
   a_rx_clock_gate: assert property (!s_q.clockStop[CS_RX_AUTO] |-> rxClockRun)
      else $error("rx clock stopped without auto mode");
   a_serial_restart: assert property (s_q.clockStop[CS_SER_AUTO] && (|frameSync) |=> !serialPowerDown)
      else $error("frame sync did not restart serial interface");
   a_status_latched: assert property ((s_q.rxStatus[6:1] != 6'h0) && !rdStatus
                                      |=> (s_q.rxStatus[6:1] & $past(s_q.rxStatus[6:1]))
                                          == $past(s_q.rxStatus[6:1]))
      else $error("receive flag dropped without a read");
   a_scan_top_hold: assert property (s_q.scanState == SCAN_RUN && s_q.scanUp && atEnd
                                     && !s_q.scanCtrl[SC_AUTO] && s_q.scanCtrl[SC_DIR]
                                     && s_q.scanCtrl[SC_RAM_SRC] |=> s_q.ptr == PTR_TOP)
      else $error("pointer left top while scanning up");
   a_dac1_source: assert property (s_q.scanCtrl[SC_RAM_SRC] |=> dac1Data == $past(ramData))
      else $error("dac1 not fed from ram");
   a_loop_alternate: assert property (digitalLoopback && sampleTick |=> rxPortIsQ != $past(rxPortIsQ))
      else $error("loopback did not alternate channels");

   // scan direction, serial idle, status clear and capture checks
   a_scan_dir_hold: assert property (s_q.scanState == SCAN_RUN && !(scanTick && atEnd)
                                     |=> s_q.scanUp == $past(s_q.scanUp))
      else $error("scan direction changed before scan end");
   a_bounce_reverse: assert property (s_q.scanState == SCAN_RUN && s_q.scanCtrl[SC_RAM_SRC]
                                      && s_q.scanCtrl[SC_AUTO] && scanTick && atEnd
                                      |=> s_q.scanUp != $past(s_q.scanUp))
      else $error("auto cycle did not reverse at end");
   a_serial_idle_down: assert property (s_q.clockStop[CS_SER_AUTO] && !(|frameSync) && symbolTick
                                        && s_q.idleSyms == 3'(SER_IDLE_SYMS - 3'h1) |=> serialPowerDown)
      else $error("serial interface stayed up after idle symbols");
   a_status_clear: assert property (rdStatus && (rxFlagEvents == 6'h00)
                                    |=> s_q.rxStatus[6:1] == 6'h00)
      else $error("receive flags not cleared by status read");
   a_loop_capture: assert property (digitalLoopback && sampleTick && !rxPortIsQ
                                    |=> rxPortData == $past(txOperI))
      else $error("loopback did not capture I sample");

   c_phase_write: cover property (wrPhase ##1 phaseAdvance);
   c_scan_bounce: cover property (s_q.scanCtrl[SC_AUTO] && atEnd && scanTick ##1 !$stable(s_q.scanUp));
   c_serial_down: cover property ($rose(serialPowerDown));
   c_status_read: cover property (rdStatus && (s_q.rxStatus[6:1] != 6'h0));
   c_loop_q: cover property (digitalLoopback && sampleTick && rxPortIsQ);

endmodule // baseband_clock_loopback_control
`default_nettype wire

// >>> baseband_clock_loopback_control_tb.sv
// self-checking testbench for the clock stop, loopback and scan register block
`timescale 1ns/100ps
`default_nettype none
module baseband_clock_loopback_control_tb;
   import bbclk_pkg::*;
   logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rxIrq, phaseStepPulse, phaseRetard;
   logic        phaseAdvance, txPathEnable, rxPathEnable, txClockRun, rxClockRun, fifoClockRun, rxPortPowerDown;
   logic        ramDacPowerDown, symbolTick, serialPowerDown, biasPowerDown, fastPins, rxFilterBypass;
   logic        txFilterBypass, iirBypass, codecRate32k, codecWord16, codecLoopback, analogueLoopback;
   logic        rxAccessEnable, txAccessEnable, digitalLoopback, sampleTick, rxPortIsQ;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb, auxDacPowerDown;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [6:1]  rxFlagEvents;
   logic [2:0]  phaseEighths, frameSync, stepSeen, eighthsSeen;
   logic [15:0] txOperI, txOperQ, rxPortData;
   logic [5:0]  ramAddr;
   logic [9:0]  ramData, auxDac1Value, dac1Data;
   logic [7:0]  msk [6] = '{MASK_RX_MASK, MASK_PHASE_STEP, MASK_CLOCK_STOP, MASK_POWER_DOWN, MASK_LOOPBACK, MASK_SCAN_CTRL};
   logic [2:0]  eighths [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h2, 3'h1};
   int          n_mismatch = 0;
   int          checks = 0;
   int          waitN;

   baseband_clock_loopback_control uut (
      .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxFlagEvents, .rxIrq, .phaseStepPulse,
      .phaseRetard, .phaseAdvance, .phaseEighths, .txPathEnable, .rxPathEnable, .txClockRun, .rxClockRun,
      .fifoClockRun, .rxPortPowerDown, .ramDacPowerDown, .symbolTick, .frameSync, .serialPowerDown,
      .biasPowerDown, .auxDacPowerDown, .fastPins, .rxFilterBypass, .txFilterBypass, .iirBypass, .codecRate32k,
      .codecWord16, .codecLoopback, .analogueLoopback, .rxAccessEnable, .txAccessEnable, .digitalLoopback,
      .sampleTick, .txOperI, .txOperQ, .rxPortData, .rxPortIsQ, .ramAddr, .ramData, .auxDac1Value, .dac1Data
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic wrap_up;
      $display("mismatches %0d of %0d checks", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // every wait is cut short here
   task automatic bound(inout int n);
      n++;
      if (n > 2000) begin
         n_mismatch++;
         wrap_up();
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] rsp);
      logic aR, wR, bV;
      int   n;
      n = 0;
      bV = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, val};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!bV) begin
         #1;
         {aR, wR, bV} = {s_axi_awready, s_axi_wready, s_axi_bvalid === 1'b1};
         {stepSeen, eighthsSeen, rsp} = {phaseStepPulse, phaseRetard, phaseAdvance, phaseEighths, s_axi_bresp};
         @(posedge clk);
         if (aR === 1'b1) s_axi_awvalid <= 1'b0;
         if (wR === 1'b1) s_axi_wvalid <= 1'b0;
         if (bV) s_axi_bready <= 1'b0;
         bound(n);
      end
   endtask

   task automatic rd(input logic [7:0] idx, output logic [1:0] rsp, output logic [31:0] dat);
      logic arR, rV;
      int   n;
      n = 0;
      rV = 1'b0;
      @(posedge clk);
      s_axi_araddr <= {2'b00, idx, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      while (!rV) begin
         #1;
         {arR, rV, rsp, dat} = {s_axi_arready, s_axi_rvalid === 1'b1, s_axi_rresp, s_axi_rdata};
         @(posedge clk);
         if (arR === 1'b1) s_axi_arvalid <= 1'b0;
         if (rV) s_axi_rready <= 1'b0;
         bound(n);
      end
   endtask

   // first change resynchronises, second one is timed
   task automatic gap(input int expGap, input logic [5:0] expStep);
      logic [5:0] a0;
      int         n, g;
      n = 0;
      #1;
      for (int k = 0; k < 2; k++) begin
         a0 = ramAddr;
         g = 0;
         while (ramAddr === a0) begin
            @(posedge clk);
            #1;
            g++;
            bound(n);
         end
      end
      chk("scan interval", g, expGap);
      chk("scan step", 6'(ramAddr - a0), expStep);
   endtask

   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, txPathEnable, rxPathEnable} = '0;
      {symbolTick, sampleTick, rxFlagEvents, frameSync, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_wstrb, txOperI, txOperQ, ramData, auxDac1Value} = {4'h1, 16'h1111, 16'h2222, 10'h2AA, 10'h155};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(IDX_RX_MASK + 8'(i), resp, rdat);
         chk("reset value", rdat, 32'h0000_0000);
         wr(IDX_RX_MASK + 8'(i), 8'hFF, resp);
         rd(IDX_RX_MASK + 8'(i), resp, rdat);
         chk("stored bits", rdat, {24'h00_0000, msk[i]});
         wr(IDX_RX_MASK + 8'(i), 8'h00, resp);
      end
      for (int c = 0; c < 8; c++) begin
         wr(IDX_PHASE_STEP, 8'(c), resp);
         chk("step kind", stepSeen, {1'b1, 1'(c > 0 && c < 4), 1'(c > 3)});
         chk("step size", eighthsSeen, eighths[c]);
         rd(IDX_PHASE_STEP, resp, rdat);
         chk("phase readback", rdat, 32'(c));
      end
      wr(IDX_PHASE_STEP, 8'h07, resp);
      chk("repeated step", stepSeen, 3'b101);
      wr(IDX_CLOCK_STOP, 8'h21, resp);
      cyc(1);
      chk("gated path clocks", {txClockRun, rxClockRun}, 2'b00);
      @(posedge clk) {txPathEnable, rxPathEnable} <= 2'b11;
      cyc(1);
      chk("enabled path clocks", {txClockRun, rxClockRun}, 2'b11);
      @(posedge clk) {txPathEnable, rxPathEnable} <= 2'b00;
      wr(IDX_CLOCK_STOP, 8'h1C, resp);
      cyc(1);
      chk("clock stop outputs", {fifoClockRun, rxPortPowerDown, ramDacPowerDown}, 3'b111);
      chk("free path clocks", {txClockRun, rxClockRun}, 2'b11);
      for (int k = 0; k < 2; k++) begin
         wr(IDX_POWER_DOWN, k ? 8'h2A : 8'h15, resp);
         cyc(1);
         chk("power down", {fastPins, biasPowerDown, auxDacPowerDown}, k ? 6'h2A : 6'h15);
      end
      for (int i = 0; i < 8; i++) begin
         wr(IDX_LOOPBACK, 8'(1 << i), resp);
         cyc(1);
         chk("routing", {rxFilterBypass, txFilterBypass, iirBypass, codecLoopback, analogueLoopback,
            rxAccessEnable, txAccessEnable, digitalLoopback}, 32'(1 << i));
         chk("codec mode", {codecRate32k, codecWord16}, (i == 5) ? 2'b11 : 2'b00);
      end
      wr(IDX_LOOPBACK, 8'h01, resp);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) sampleTick <= 1'b1;
         @(posedge clk) sampleTick <= 1'b0;
         #1;
         chk("looped sample", rxPortData, k ? 16'h2222 : 16'h1111);
         chk("next channel", rxPortIsQ, k ? 1'b0 : 1'b1);
      end
      wr(IDX_RX_MASK, 8'h04, resp);
      @(posedge clk) rxFlagEvents <= 6'h04;
      @(posedge clk) rxFlagEvents <= 6'h00;
      cyc(2);
      chk("masked flag", rxIrq, 1'b0);
      @(posedge clk) rxFlagEvents <= 6'h02;
      @(posedge clk) rxFlagEvents <= 6'h00;
      cyc(2);
      chk("unmasked flag", rxIrq, 1'b1);
      rd(IDX_RX_STATUS, resp, rdat);
      chk("latched flags", rdat, 32'h0000_000D);
      rd(IDX_RX_STATUS, resp, rdat);
      chk("flags after read", rdat, 32'h0000_0000);
      cyc(1);
      chk("irq after read", rxIrq, 1'b0);
      wr(IDX_CLOCK_STOP, 8'h02, resp);
      for (int k = 1; k <= 6; k++) begin
         @(posedge clk) symbolTick <= 1'b1;
         @(posedge clk) symbolTick <= 1'b0;
         #1;
         chk("serial idle stop", serialPowerDown, k == 6);
      end
      @(posedge clk) frameSync <= 3'h4;
      @(posedge clk) frameSync <= 3'h0;
      cyc(1);
      chk("serial restart", serialPowerDown, 1'b0);
      wr(IDX_SCAN_CTRL, 8'h05, resp);
      gap(512, 6'h01);
      wr(IDX_SCAN_CTRL, 8'h3D, resp);
      gap(4, 6'h01);
      chk("dac1 from ram", dac1Data, 10'h2AA);
      wr(IDX_SCAN_CTRL, 8'h3F, resp);
      waitN = 0;
      while (ramAddr !== 6'h3F) begin
         @(posedge clk);
         #1;
         bound(waitN);
      end
      gap(4, 6'h3F);
      wr(IDX_SCAN_CTRL, 8'h3D, resp);
      gap(4, 6'h3F);
      wr(IDX_SCAN_CTRL, 8'h3C, resp);
      cyc(2);
      chk("dac1 from register", dac1Data, 10'h155);
      wr(8'h30, 8'h55, resp);
      chk("unmapped write", resp, RESP_SLVERR);
      rd(8'h30, resp, rdat);
      chk("unmapped read", resp, RESP_SLVERR);
      wrap_up();
   end
endmodule // baseband_clock_loopback_control_tb
`default_nettype wire
